// *** sgp_board.sv ***
`timescale 1ns/100ps
module sgp_board (
  input  wire logic [2:0] i_out,
  input  wire logic [2:0] i_oe,
  input  wire logic [2:0] i_lvl,
  output logic      [2:0] o_pin
);
  // driven pins follow the device, others the board
  assign o_pin = (i_oe & i_out) | (~i_oe & i_lvl);
endmodule : sgp_board

// *** sgp_gpio.sv ***
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module sgp_gpio (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire logic [sgp_pkg::SGP_AW-1:0] i_awaddr,
  input  wire logic                   i_awvalid,
  output logic                        o_awready,
  input  wire logic [31:0]            i_wdata,
  input  wire logic [3:0]             i_wstrb,
  input  wire logic                   i_wvalid,
  output logic                        o_wready,
  output logic [1:0]                  o_bresp,
  output logic                        o_bvalid,
  input  wire logic                   i_bready,
  input  wire logic [sgp_pkg::SGP_AW-1:0] i_araddr,
  input  wire logic                   i_arvalid,
  output logic                        o_arready,
  output logic [31:0]                 o_rdata,
  output logic [1:0]                  o_rresp,
  output logic                        o_rvalid,
  input  wire logic                   i_rready,
  input  wire logic [2:0]             i_pin_in,
  output logic [2:0]                  o_pin_out,
  output logic [2:0]                  o_pin_oe
);
  import sgp_pkg::*;

  logic [2:0]            sync1_r;
  logic [2:0]            sync2_r;
  logic [2:0]            dir_r;
  logic [2:0]            val_r;
  logic                  aw_have_r;
  logic                  w_have_r;
  logic [SGP_AW-1:0]     awaddr_r;
  logic [31:0]           wdata_r;
  logic [3:0]            wstrb_r;

  // byte lane that carries a bit of the data word
  function automatic int sgp_lane(input int pos);
    return pos / 8;
  endfunction : sgp_lane

  // gathers one field of each pin, pin three in bit 0
  function automatic logic [2:0] sgp_pick3(input logic [31:0] word, input int b3, input int b4, input int b5);
    return {word[b5], word[b4], word[b3]};
  endfunction : sgp_pick3

  // per-pin update; pins whose lane is not strobed keep their bits
  function automatic logic [2:0] sgp_merge(input logic [2:0] old, input logic [2:0] upd, input logic [2:0] we);
    return (old & ~we) | (upd & we);
  endfunction : sgp_merge

  // only the configuration word is mapped
  function automatic logic sgp_hit(input logic [SGP_AW-1:0] addr);
    return addr == SGP_CFG_OFF;
  endfunction : sgp_hit

  // refuse constants that the decode cannot serve
  if (SGP_AW < 2 || SGP_AW > 32) begin : g_bad_aw
    $error("address width out of range");
  end
  if (SGP_CFG_OFF[1:0] != 2'h0) begin : g_bad_off
    $error("register offset not word aligned");
  end
  // a pin is written from one byte lane, so its two control fields must share it
  if (sgp_lane(SGP_P3_DIR_BIT) != sgp_lane(SGP_P3_OUT_BIT)) begin : g_bad_p3
    $error("pin three fields split across byte lanes");
  end
  if (sgp_lane(SGP_P4_DIR_BIT) != sgp_lane(SGP_P4_OUT_BIT)) begin : g_bad_p4
    $error("pin four fields split across byte lanes");
  end
  if (sgp_lane(SGP_P5_DIR_BIT) != sgp_lane(SGP_P5_OUT_BIT)) begin : g_bad_p5
    $error("pin five fields split across byte lanes");
  end
  if (SGP_P3_IN_BIT > 31 || SGP_P4_IN_BIT > 31 || SGP_P5_IN_BIT > 31) begin : g_bad_in
    $error("pin level field beyond the data word");
  end
  if (SGP_P3_OUT_BIT > 31 || SGP_P4_OUT_BIT > 31 || SGP_P5_OUT_BIT > 31) begin : g_bad_out
    $error("pin control field beyond the data word");
  end

  wire                   aw_take  = i_awvalid & o_awready;
  wire                   w_take   = i_wvalid & o_wready;
  wire                   aw_ok    = aw_have_r | aw_take;
  wire                   w_ok     = w_have_r | w_take;
  wire [SGP_AW-1:0]      wr_addr  = aw_take ? i_awaddr : awaddr_r;
  // a beat taken on an earlier edge is replayed from its holding register
  wire [31:0]            wr_data  = w_take ? i_wdata : wdata_r;
  wire [3:0]             wr_strb  = w_take ? i_wstrb : wstrb_r;
  wire                   wr_fire  = aw_ok & w_ok & ~o_bvalid;
  wire                   wr_hit   = sgp_hit(wr_addr);
  // a pin changes only when its own byte lane is strobed
  wire [2:0]             pin_we   = {3{wr_fire & wr_hit}} & {wr_strb[sgp_lane(SGP_P5_DIR_BIT)],
                                     wr_strb[sgp_lane(SGP_P4_DIR_BIT)], wr_strb[sgp_lane(SGP_P3_DIR_BIT)]};
  wire                   rd_take  = i_arvalid & o_arready;
  wire                   rd_hit   = sgp_hit(i_araddr);
  wire [2:0]             dir_nxt  = sgp_pick3(wr_data, SGP_P3_DIR_BIT,
                                              SGP_P4_DIR_BIT, SGP_P5_DIR_BIT);
  wire [2:0]             val_nxt  = sgp_pick3(wr_data, SGP_P3_OUT_BIT,
                                              SGP_P4_OUT_BIT, SGP_P5_OUT_BIT);
  wire [2:0]             dir_new  = sgp_merge(dir_r, dir_nxt, pin_we);
  wire [2:0]             val_new  = sgp_merge(val_r, val_nxt, pin_we);
  logic [31:0]           cfg_word;

  // all other bits stay zero
  always_comb begin
    cfg_word                 = 32'h0;
    cfg_word[SGP_P3_IN_BIT]  = sync2_r[0];
    cfg_word[SGP_P3_DIR_BIT] = dir_r[0];
    cfg_word[SGP_P3_OUT_BIT] = val_r[0];
    cfg_word[SGP_P4_IN_BIT]  = sync2_r[1];
    cfg_word[SGP_P4_DIR_BIT] = dir_r[1];
    cfg_word[SGP_P4_OUT_BIT] = val_r[1];
    cfg_word[SGP_P5_IN_BIT]  = sync2_r[2];
    cfg_word[SGP_P5_DIR_BIT] = dir_r[2];
    cfg_word[SGP_P5_OUT_BIT] = val_r[2];
  end

  // pin input synchroniser; reads 1 until the pins are sampled
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_r <= SGP_IN_RST;
      sync2_r <= SGP_IN_RST;
    end else begin
      sync1_r <= i_pin_in;
      sync2_r <= sync1_r;
    end
  end

  // control bits; unstrobed pins keep their value
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_r <= SGP_DIR_RST;
      val_r <= SGP_OUT_RST;
    end else begin
      dir_r <= dir_new;
      val_r <= val_new;
    end
  end

  // pins follow the registered control bits, driven only as outputs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_oe  <= SGP_DIR_RST;
      o_pin_out <= SGP_OUT_RST;
    end else begin
      o_pin_oe  <= dir_new;
      o_pin_out <= val_new & dir_new;
    end
  end

  // address and data come in either order; each waits for the other
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= SGP_RESP_OKAY;
    end else begin
      if (aw_take) awaddr_r <= i_awaddr;
      if (w_take) begin
        wdata_r  <= i_wdata;
        wstrb_r  <= i_wstrb;
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        o_awready <= 1'b0;
        o_wready  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= wr_hit ? SGP_RESP_OKAY : SGP_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_have_r <= 1'b1;
          o_awready <= 1'b0;
        end
        if (w_take) begin
          w_have_r <= 1'b1;
          o_wready <= 1'b0;
        end
        if (o_bvalid && i_bready) begin
          o_bvalid  <= 1'b0;
          o_awready <= 1'b1;
          o_wready  <= 1'b1;
        end
      end
    end
  end

  // one read at a time; unmapped addresses answer zero with an error
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0;
      o_rresp   <= SGP_RESP_OKAY;
    end else if (rd_take) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rd_hit ? cfg_word : 32'h0;
      o_rresp   <= rd_hit ? SGP_RESP_OKAY : SGP_RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end
endmodule : sgp_gpio

// *** sgp_gpio_sva.sv ***
`timescale 1ns/100ps
module sgp_gpio_sva (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [sgp_pkg::SGP_AW-1:0] i_awaddr,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0]  i_wstrb,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic        o_rvalid,
  input wire logic [2:0]  o_pin_out,
  input wire logic [2:0]  o_pin_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [31:0] d_r;
  logic [3:0]  s_r;
  wire tk = i_awvalid & o_awready & i_wvalid & o_wready;
  wire wr = tk & (i_awaddr == sgp_pkg::SGP_CFG_OFF);
  wire [2:0] we = {s_r[2], s_r[2], s_r[1]};
  always_ff @(posedge i_clk) d_r <= i_wdata;
  always_ff @(posedge i_clk) s_r <= i_wstrb;
  a_dir_write: assert property (wr |=> o_pin_oe == (($past(o_pin_oe) & ~we) |
    ({d_r[21], d_r[17], d_r[13]} & we)))
    else $error("pin direction not taken from write");
  a_out_write: assert property (wr |=> o_pin_out == (($past(o_pin_out) & ~we) |
    ({d_r[22], d_r[18], d_r[14]} & {d_r[21], d_r[17], d_r[13]} & we)))
    else $error("pin value not taken from write");
  a_out_mask: assert property ((o_pin_out & ~o_pin_oe) == 3'h0)
    else $error("input pin driven");
  a_pins_hold: assert property (!$rose(o_bvalid) |-> $stable(o_pin_oe) && $stable(o_pin_out))
    else $error("pins changed without a write");
  a_rsvd_zero: assert property (o_rvalid |-> (o_rdata & ~32'h00777000) == 32'h0)
    else $error("reserved bits not zero");
  a_rst_idle: assert property ($rose(i_rst_n) |-> o_pin_oe == 3'h0 && o_pin_out == 3'h0)
    else $error("pins not idle after reset");
  a_wr_answer: assert property (tk |=> o_bvalid)
    else $error("write not answered");
  a_rd_answer: assert property (i_arvalid && o_arready |=> o_rvalid ##1 1'b1)
    else $error("read not answered");
endmodule : sgp_gpio_sva
bind sgp_gpio sgp_gpio_sva u_sva (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));

// *** sgp_pkg.sv ***
package sgp_pkg;
  localparam int          SGP_AW          = 4;
  localparam logic [3:0]  SGP_CFG_OFF     = 4'h0;
  localparam int          SGP_P3_IN_BIT   = 12;
  localparam int          SGP_P3_DIR_BIT  = 13;
  localparam int          SGP_P3_OUT_BIT  = 14;
  localparam int          SGP_P4_IN_BIT   = 16;
  localparam int          SGP_P4_DIR_BIT  = 17;
  localparam int          SGP_P4_OUT_BIT  = 18;
  localparam int          SGP_P5_IN_BIT   = 20;
  localparam int          SGP_P5_DIR_BIT  = 21;
  localparam int          SGP_P5_OUT_BIT  = 22;
  localparam logic [2:0]  SGP_IN_RST      = 3'h7;
  localparam logic [2:0]  SGP_DIR_RST     = 3'h0;
  localparam logic [2:0]  SGP_OUT_RST     = 3'h0;
  localparam logic [1:0]  SGP_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SGP_RESP_SLVERR = 2'h2;
endpackage : sgp_pkg

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
  import sgp_pkg::*;
  logic i_clk = 0, i_rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic awr, wrd, bv, arr, rv;
  logic [3:0] awa = 0, ara = 0, stb = 0;
  logic [31:0] wd = 0, lf = 32'h49, cfg = 0, rdt;
  logic [2:0] lvl = 3'h7, pin, po, oe;
  logic [1:0] br, rr;
  int miscompares = 0, checked = 0, cyc = 0;
  always #50 i_clk = ~i_clk;
  sgp_gpio uut (.i_clk, .i_rst_n, .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(stb),
    .i_wvalid(wv), .o_wready(wrd), .o_bresp(br), .o_bvalid(bv), .i_bready(bry), .i_araddr(ara), .i_arvalid(arv),
    .o_arready(arr), .o_rdata(rdt), .o_rresp(rr), .o_rvalid(rv), .i_rready(rry), .i_pin_in(pin), .o_pin_out(po),
    .o_pin_oe(oe));
  sgp_board u_brd (.i_out(po), .i_oe(oe), .i_lvl(lvl), .o_pin(pin));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [31:0] expv();
    logic [31:0] m;
    m = cfg;
    for (int k = 0; k < 3; k++) m[12+4*k] = cfg[13+4*k] ? cfg[14+4*k] : lvl[k];
    return m;
  endfunction : expv
  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic wr(input logic [3:0] a, s, input logic [31:0] d, input logic [1:0] er);
    logic [31:0] m;
    @(posedge i_clk);
    awa <= a;
    wd <= d;
    stb <= s;
    {awv, wv, bry} <= 3'h7;
    do begin
      @(posedge i_clk);
      if (awv && awr) awv <= 0;
      if (wv && wrd) wv <= 0;
    end while (!bv);
    bry <= 0;
    chk("bresp", br, er);
    if (a == SGP_CFG_OFF) begin
      m = {8'h0, {8{s[2]}}, {8{s[1]}}, 8'h0} & 32'h00666000;
      cfg = (cfg & ~m) | (d & m);
    end
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge i_clk);
    ara <= a;
    {arv, rry} <= 2'h3;
    do begin
      @(posedge i_clk);
      if (arv && arr) arv <= 0;
    end while (!rv);
    rry <= 0;
    chk("rdata", rdt, e);
    chk("rresp", rr, er);
  endtask : rd
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1;
    repeat (3) @(posedge i_clk);
    rd(SGP_CFG_OFF, 32'h00111000, SGP_RESP_OKAY);
    for (int i = 0; i < 12; i++) begin
      lf = lfsr(lf);
      lvl <= lf[26:24];
      wr(SGP_CFG_OFF, i[0] ? 4'hf : lf[31:28], lf, SGP_RESP_OKAY);
      chk("oe", oe, {cfg[21], cfg[17], cfg[13]});
      chk("out", po, {cfg[22] & cfg[21], cfg[18] & cfg[17], cfg[14] & cfg[13]});
      repeat (3) @(posedge i_clk);
      rd(SGP_CFG_OFF, expv(), SGP_RESP_OKAY);
    end
    wr(SGP_CFG_OFF, 4'hb, 32'hffffffff, SGP_RESP_OKAY);
    wr(4'h4, 4'hf, 32'hffffffff, SGP_RESP_SLVERR);
    rd(4'h4, 32'h0, SGP_RESP_SLVERR);
    rd(SGP_CFG_OFF, expv(), SGP_RESP_OKAY);
    conclude();
  end
endmodule : testbench
